// ### hw/tdic_top.sv
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
// Behaviour
// RULE1: Eight independent isolated channels, each with own path and settings.
// RULE2: Every channel is sampled and updated once per 5 ms scan.
// RULE3: Per-channel upper trip voltage, 0.1 V steps, default 88 V.
// RULE4: Per-channel lower trip voltage, 0.1 V steps, default 60 V.
// RULE5: Normally open: above upper trip active, below lower trip inactive.
// RULE6: Normally closed: above upper trip inactive, below lower active.
// RULE7: Per-channel polarity, default normally open, sets energized level.
// RULE8: Rising change waits a programmable delay, 1 ms steps, default 0.
// RULE9: Falling change waits a programmable delay, 1 ms steps, default 0.
// RULE10: Alternating supply option adds 30 ms to falling delay; default off.
// RULE11: With that option the lower trip is ten percent of upper trip.
// RULE12: Per-channel 32-bit counter of rising changes, reset to zero.
// RULE13: Clear command zeroes a channel counter; idle value does nothing.
// RULE14: Present channel voltage is reported with 1 mV resolution.
// RULE15: Trip settings are stored and applied per channel.
// RULE16: Channel k is numbered k plus the count of preceding inputs.
// RULE17: Between the trip voltages a channel keeps its previous raw state.
// RULE18: Delays count whole scan ticks; reverting raw state cancels them.
module tdic_top #(
  parameter int SCAN_CYCLES = tdic_pkg::SCAN_CYCLES,
  parameter logic [7:0] CHAN_BASE = 8'h00
) (
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire tdic_pkg::tdic_bus_req_t BUS_I,
  input wire tdic_pkg::tdic_volt_bus_t VOLT_I,
  output logic [31:0] RDATA_O,
  output logic [tdic_pkg::NCH-1:0] STATE_O,
  output logic IRQ_O
);

  tdic_pkg::tdic_state_t st_reg;
  tdic_pkg::tdic_state_t st_next;

  // ****************************************************************
  // Next-state logic.
  // ****************************************************************
  // The voltage bus comes from the on-card converter logic on this same
  // clock, so it is read without synchronising flops.
  always_comb begin
    logic [19:0] up_mv;
    logic [19:0] lo_mv;
    logic [19:0] vin;
    logic [21:0] dly;
    logic en;
    logic raw;
    logic [2:0] idx;
    logic [2:0] sel;
    logic [2*tdic_pkg::NCH-1:0] ev;
    logic [tdic_pkg::NCH-1:0] clr;
    logic [2*tdic_pkg::NCH-1:0] w1c;
    up_mv = 20'h00000;
    lo_mv = 20'h00000;
    vin = 20'h00000;
    dly = 22'h000000;
    en = 1'b0;
    raw = 1'b0;
    idx = BUS_I.addr[7:5];
    sel = BUS_I.addr[4:2];
    ev = '0;
    clr = '0;
    w1c = '0;
    st_next = st_reg;

    // RULE2: scan tick divider.
    st_next.tick = 1'b0;
    if (st_reg.tick_cnt == 20'(SCAN_CYCLES - 1)) begin
      st_next.tick_cnt = 20'h00000;
      st_next.tick = 1'b1;
    end else begin
      st_next.tick_cnt = st_reg.tick_cnt + 20'h00001;
    end

    if (BUS_I.we) begin
      if (BUS_I.addr == tdic_pkg::REG_IRQ_STATUS) begin
        w1c = BUS_I.wdata[2*tdic_pkg::NCH-1:0];
      end else if (BUS_I.addr == tdic_pkg::REG_IRQ_MASK) begin
        st_next.irq_mask = BUS_I.wdata[2*tdic_pkg::NCH-1:0];
      end else if (BUS_I.addr == tdic_pkg::REG_CNT_CLEAR) begin
        // RULE13: one bit per channel.
        clr = BUS_I.wdata[tdic_pkg::NCH-1:0];
      end else if (BUS_I.addr[11:8] == tdic_pkg::CH_PAGE) begin
        // RULE15: per-channel settings.
        if (sel == tdic_pkg::CH_UPPER_TRIP) begin
          st_next.ch[idx].upper_trip = BUS_I.wdata[tdic_pkg::THR_W-1:0];
        end else if (sel == tdic_pkg::CH_LOWER_TRIP) begin
          st_next.ch[idx].lower_trip = BUS_I.wdata[tdic_pkg::THR_W-1:0];
        end else if (sel == tdic_pkg::CH_ACT_DELAY) begin
          st_next.ch[idx].act_delay = BUS_I.wdata[tdic_pkg::DLY_W-1:0];
        end else if (sel == tdic_pkg::CH_DROP_DELAY) begin
          st_next.ch[idx].drop_delay = BUS_I.wdata[tdic_pkg::DLY_W-1:0];
        end else if (sel == tdic_pkg::CH_CONFIG) begin
          // RULE7: polarity select.
          st_next.ch[idx].nc = BUS_I.wdata[tdic_pkg::CFG_NC_BIT];
          st_next.ch[idx].ac = BUS_I.wdata[tdic_pkg::CFG_AC_BIT];
        end
      end
    end

    // RULE1: identical path per channel.
    for (int i = 0; i < tdic_pkg::NCH; i++) begin
      // RULE13: zero the counter.
      if (clr[i]) begin
        st_next.ch[i].count = '0;
      end
      if (st_reg.tick) begin
        vin = {1'b0, VOLT_I[i]};
        // RULE14: voltage report in millivolts.
        st_next.ch[i].volt = VOLT_I[i];
        up_mv = 20'(st_reg.ch[i].upper_trip) * tdic_pkg::DECIVOLT_TO_MV;
        // RULE11: forced release level.
        if (st_reg.ch[i].ac) begin
          lo_mv = 20'(st_reg.ch[i].upper_trip) * tdic_pkg::AC_RELEASE_MUL;
        end else begin
          lo_mv = 20'(st_reg.ch[i].lower_trip) * tdic_pkg::DECIVOLT_TO_MV;
        end
        // RULE17: hysteresis hold.
        en = st_reg.ch[i].energized;
        if (vin > up_mv) begin
          en = 1'b1;
        end else if (vin < lo_mv) begin
          en = 1'b0;
        end
        st_next.ch[i].energized = en;
        // RULE5: RULE6: polarity applied.
        raw = en ^ st_reg.ch[i].nc;
        // RULE8: RULE9: pick delay.
        if (raw) begin
          dly = {1'b0, st_reg.ch[i].act_delay};
        end else if (st_reg.ch[i].ac) begin
          // RULE10: extra AC drop-off.
          dly = {1'b0, st_reg.ch[i].drop_delay} + tdic_pkg::AC_EXTRA_MS;
        end else begin
          dly = {1'b0, st_reg.ch[i].drop_delay};
        end
        // RULE18: whole ticks, cancel on revert.
        if (raw == st_reg.ch[i].state) begin
          st_next.ch[i].dly_cnt = 22'h000000;
        end else if (st_reg.ch[i].dly_cnt >= dly) begin
          st_next.ch[i].dly_cnt = 22'h000000;
          st_next.ch[i].state = raw;
          ev[i] = raw;
          ev[tdic_pkg::NCH + i] = ~raw;
          // RULE12: count rising changes.
          if (raw) begin
            st_next.ch[i].count = st_next.ch[i].count + 32'h00000001;
          end
        end else begin
          st_next.ch[i].dly_cnt = st_reg.ch[i].dly_cnt
            + tdic_pkg::SCAN_STEP_MS;
        end
      end
    end

    // A new event in the cycle of its clear stays set.
    st_next.irq_status = (st_reg.irq_status & ~w1c) | ev;
    st_next.irq = |(st_next.irq_status & st_next.irq_mask);

    // ****************************************************************
    // Read path, one cycle latency.
    // ****************************************************************
    st_next.rdata = 32'h00000000;
    if (BUS_I.re) begin
      if (BUS_I.addr == tdic_pkg::REG_STATE) begin
        for (int i = 0; i < tdic_pkg::NCH; i++) begin
          st_next.rdata[i] = st_reg.ch[i].state;
        end
      end else if (BUS_I.addr == tdic_pkg::REG_IRQ_STATUS) begin
        st_next.rdata = 32'(st_reg.irq_status);
      end else if (BUS_I.addr == tdic_pkg::REG_IRQ_MASK) begin
        st_next.rdata = 32'(st_reg.irq_mask);
      end else if (BUS_I.addr == tdic_pkg::REG_CHAN_BASE) begin
        // RULE16: channel numbering offset.
        st_next.rdata = 32'(CHAN_BASE);
      end else if (BUS_I.addr[11:8] == tdic_pkg::CH_PAGE) begin
        if (sel == tdic_pkg::CH_UPPER_TRIP) begin
          st_next.rdata = 32'(st_reg.ch[idx].upper_trip);
        end else if (sel == tdic_pkg::CH_LOWER_TRIP) begin
          st_next.rdata = 32'(st_reg.ch[idx].lower_trip);
        end else if (sel == tdic_pkg::CH_ACT_DELAY) begin
          st_next.rdata = 32'(st_reg.ch[idx].act_delay);
        end else if (sel == tdic_pkg::CH_DROP_DELAY) begin
          st_next.rdata = 32'(st_reg.ch[idx].drop_delay);
        end else if (sel == tdic_pkg::CH_CONFIG) begin
          st_next.rdata[tdic_pkg::CFG_NC_BIT] = st_reg.ch[idx].nc;
          st_next.rdata[tdic_pkg::CFG_AC_BIT] = st_reg.ch[idx].ac;
        end else if (sel == tdic_pkg::CH_COUNTER) begin
          st_next.rdata = st_reg.ch[idx].count;
        end else if (sel == tdic_pkg::CH_VOLTAGE) begin
          st_next.rdata = 32'(st_reg.ch[idx].volt);
        end
      end
    end
  end

  // ****************************************************************
  // State register.
  // ****************************************************************
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      st_reg <= '0;
      for (int i = 0; i < tdic_pkg::NCH; i++) begin
        // RULE3: RULE4: trip defaults.
        st_reg.ch[i].upper_trip <= tdic_pkg::UPPER_TRIP_RST;
        st_reg.ch[i].lower_trip <= tdic_pkg::LOWER_TRIP_RST;
      end
    end else begin
      st_reg <= st_next;
    end
  end

  assign RDATA_O = st_reg.rdata;
  assign IRQ_O = st_reg.irq;
  for (genvar g = 0; g < tdic_pkg::NCH; g++) begin : g_state
    assign STATE_O[g] = st_reg.ch[g].state;
  end

endmodule

// ### hw/tdic_pkg.sv
package tdic_pkg;

  // ****************************************************************
  // Channel count and timing.
  // ****************************************************************
  localparam int NCH = 8;
  localparam int CLK_MHZ = 125;
  localparam int SCAN_PERIOD_US = 5000;
  localparam int SCAN_CYCLES = SCAN_PERIOD_US * CLK_MHZ;
  localparam logic [21:0] SCAN_STEP_MS = 22'h000005;
  localparam logic [21:0] AC_EXTRA_MS = 22'h00001E;

  // ****************************************************************
  // Field widths and reset values.
  // ****************************************************************
  localparam int THR_W = 11;
  localparam int DLY_W = 21;
  localparam int VOLT_W = 19;
  localparam int CNT_W = 32;
  localparam logic [THR_W-1:0] UPPER_TRIP_RST = 11'h370;
  localparam logic [THR_W-1:0] LOWER_TRIP_RST = 11'h258;
  localparam logic [19:0] DECIVOLT_TO_MV = 20'h00064;
  localparam logic [19:0] AC_RELEASE_MUL = 20'h0000A;

  // ****************************************************************
  // Register map, byte addresses.
  // ****************************************************************
  localparam int ADDR_W = 12;
  localparam logic [11:0] REG_STATE = 12'h000;
  localparam logic [11:0] REG_IRQ_STATUS = 12'h004;
  localparam logic [11:0] REG_IRQ_MASK = 12'h008;
  localparam logic [11:0] REG_CNT_CLEAR = 12'h00C;
  localparam logic [11:0] REG_CHAN_BASE = 12'h010;
  localparam logic [3:0] CH_PAGE = 4'h1;
  localparam logic [2:0] CH_UPPER_TRIP = 3'h0;
  localparam logic [2:0] CH_LOWER_TRIP = 3'h1;
  localparam logic [2:0] CH_ACT_DELAY = 3'h2;
  localparam logic [2:0] CH_DROP_DELAY = 3'h3;
  localparam logic [2:0] CH_CONFIG = 3'h4;
  localparam logic [2:0] CH_COUNTER = 3'h5;
  localparam logic [2:0] CH_VOLTAGE = 3'h6;
  localparam int CFG_NC_BIT = 0;
  localparam int CFG_AC_BIT = 1;

  typedef logic [NCH-1:0][VOLT_W-1:0] tdic_volt_bus_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic we;
    logic re;
  } tdic_bus_req_t;

  typedef struct packed {
    logic [THR_W-1:0] upper_trip;
    logic [THR_W-1:0] lower_trip;
    logic [DLY_W-1:0] act_delay;
    logic [DLY_W-1:0] drop_delay;
    logic nc;
    logic ac;
    logic energized;
    logic state;
    logic [21:0] dly_cnt;
    logic [CNT_W-1:0] count;
    logic [VOLT_W-1:0] volt;
  } tdic_chan_t;

  typedef struct packed {
    tdic_chan_t [NCH-1:0] ch;
    logic [19:0] tick_cnt;
    logic tick;
    logic [2*NCH-1:0] irq_status;
    logic [2*NCH-1:0] irq_mask;
    logic irq;
    logic [31:0] rdata;
  } tdic_state_t;

endpackage

// ### sim/tdic_sva.sv
`timescale 1ns/1ps
// ****
// Port checker.
// ****
module tdic_sva #(
  parameter int SCAN_CYCLES = 20,
  parameter logic [7:0] CHAN_BASE = 8'h00
) (
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire tdic_pkg::tdic_bus_req_t BUS_I,
  input wire tdic_pkg::tdic_volt_bus_t VOLT_I,
  input wire logic [31:0] RDATA_O,
  input wire logic [7:0] STATE_O,
  input wire logic IRQ_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);
  // States move only on scan ticks, so quiet cycles are counted.
  logic [31:0] quiet_reg;
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) quiet_reg <= 32'h0;
    else quiet_reg <= $changed(STATE_O) ? 32'h0 : quiet_reg + 32'h1;
  end
  sequence s_rd(logic [11:0] a);
    BUS_I.re && BUS_I.addr == a;
  endsequence
  property p_idle;
    !BUS_I.re |=> RDATA_O == 32'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("stray read data");
  property p_state;
    s_rd(12'h000) |=> RDATA_O == {24'h0, $past(STATE_O)};
  endproperty
  a_state: assert property (p_state) else $error("state read");
  property p_base;
    s_rd(12'h010) |=> RDATA_O == {24'h0, CHAN_BASE};
  endproperty
  a_base: assert property (p_base) else $error("base read");
  property p_clr_rd;
    s_rd(12'h00C) |=> RDATA_O == 32'h0;
  endproperty
  a_clr_rd: assert property (p_clr_rd) else $error("clear read");
  property p_cfg;
    BUS_I.we && BUS_I.addr == 12'h110 ##1 s_rd(12'h110)
      |=> RDATA_O == {30'h0, $past(BUS_I.wdata[1:0], 2)};
  endproperty
  a_cfg: assert property (p_cfg) else $error("config");
  property p_clr;
    BUS_I.we && BUS_I.addr == 12'h00C && BUS_I.wdata[0] ##1
      (BUS_I.re && BUS_I.addr == 12'h114 && $stable(STATE_O[0]))
      |=> RDATA_O == 32'h0;
  endproperty
  a_clr: assert property (p_clr) else $error("count kept");
  property p_mask;
    BUS_I.we && BUS_I.addr == 12'h008 && BUS_I.wdata[15:0] == 16'h0
      |-> ##[1:2] !IRQ_O;
  endproperty
  a_mask: assert property (p_mask) else $error("masked irq");
  property p_scan;
    $changed(STATE_O) |-> quiet_reg >= SCAN_CYCLES - 1;
  endproperty
  a_scan: assert property (p_scan) else $error("off tick");
endmodule
bind tdic_top tdic_sva #(.SCAN_CYCLES(SCAN_CYCLES), .CHAN_BASE(CHAN_BASE))
  u_sva (.CLK_I(CLK_I), .RESETN_I(RESETN_I), .BUS_I(BUS_I),
  .VOLT_I(VOLT_I), .RDATA_O(RDATA_O), .STATE_O(STATE_O), .IRQ_O(IRQ_O));

// ### sim/tdic_field.sv
`timescale 1ns/1ps
// ****
// Field contacts.
// ****
module tdic_field (
  input wire logic clk_i,
  output tdic_pkg::tdic_volt_bus_t volt_o
);
  int mv[8];
  task automatic put(input int ch, input int v);
    mv[ch] = v > 275000 ? 275000 : v;
  endtask
  always @(posedge clk_i) begin
    for (int i = 0; i < 8; i++) volt_o[i] <= 19'(mv[i]);
  end
endmodule

// ### sim/threshold_digital_input_conditioner_tb_top.sv
`timescale 1ns/1ps
// ****
// Bench top.
// ****
module threshold_digital_input_conditioner_tb_top;
  localparam int S = 20;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic irq;
  logic [7:0] st_o;
  logic [31:0] rdata;
  tdic_pkg::tdic_bus_req_t bus = '0;
  tdic_pkg::tdic_volt_bus_t volt;
  int err_total, checks_done, cyc, stat, m, e, n;
  int up[8], lo[8], nc[8], v[8], st[8], cnt[8];
  always #4 clk = ~clk;
  tdic_top #(.SCAN_CYCLES(S), .CHAN_BASE(8'h0C)) u_dut (.CLK_I(clk),
    .RESETN_I(rstn), .BUS_I(bus), .VOLT_I(volt), .RDATA_O(rdata),
    .STATE_O(st_o), .IRQ_O(irq));
  tdic_field u_fld (.clk_i(clk), .volt_o(volt));
  task automatic results();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bo(input logic w, r, input logic [11:0] a, input int d);
    @(posedge clk);
    bus <= '{a, d, w, r};
  endtask
  task automatic rdc(input logic [11:0] a, input int x);
    bo(0, 1, a, 0);
    bo(0, 0, a, 0);
    @(negedge clk);
    chk(rdata, x);
  endtask
  task automatic wr(input logic [11:0] a, input int d);
    bo(1, 0, a, d);
    bo(0, 0, a, d);
  endtask
  task automatic wt(input int t);
    repeat (t * S) @(posedge clk);
  endtask
  task automatic model();
    for (int i = 0; i < 8; i++) begin
      e = v[i] > up[i] * 100 ? 1 : v[i] < lo[i] * 100 ? 0 : st[i] ^ nc[i];
      if ((e ^ nc[i]) != st[i]) begin
        st[i] = e ^ nc[i];
        cnt[i] += st[i];
        stat |= 1 << (i + 8 * (1 - st[i]));
      end
    end
  endtask
  // A change is due within whole ticks of the set delay.
  task automatic lat(input int b, input int k);
    n = 0;
    while (st_o[0] !== b[0] && n < k * S + 9) begin
      @(negedge clk);
      n++;
    end
    chk(n >= (k - 1) * S && n <= k * S + 2, 1);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 10000) begin
      err_total++;
      results();
    end
  end
  initial begin
    void'($urandom(32'h981F));
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      for (int j = 0; j < 5; j++)
        rdc(12'(256 + i * 32 + j * 4), j == 0 ? 880 : j == 1 ? 600 : 0);
      up[i] = 160 + $urandom % 1841;
      lo[i] = 100 + $urandom % (up[i] - 100);
      nc[i] = $urandom % 2;
      wr(12'(256 + i * 32), up[i]);
      wr(12'(260 + i * 32), lo[i]);
      wr(12'(272 + i * 32), nc[i]);
      rdc(12'(256 + i * 32), up[i]);
      rdc(12'(260 + i * 32), lo[i]);
    end
    rdc(12'h010, 12);
    rdc(12'hFFC, 0);
    model();
    for (int k = 0; k < 10; k++) begin
      m = $urandom % 65536;
      wr(12'h008, m);
      wt(3);
      e = 0;
      for (int i = 0; i < 8; i++) e |= st[i] << i;
      rdc(12'h000, e);
      rdc(12'h004, stat);
      chk(irq, (stat & m) != 0);
      wr(12'h004, 65535);
      stat = 0;
      for (int i = 0; i < 8; i++) begin
        rdc(12'(276 + i * 32), cnt[i]);
        rdc(12'(280 + i * 32), v[i]);
        n = $urandom % 5;
        v[i] = n < 2 ? up[i] * 100 + 1 - n : n < 4 ? lo[i] * 100 + 2 - n
          : (up[i] + lo[i]) * 50;
        u_fld.put(i, v[i]);
      end
      model();
    end
    wr(12'h008, 0);
    wt(3);
    wr(12'h00C, 0);
    rdc(12'h114, cnt[0]);
    bo(1, 0, 12'h00C, 255);
    for (int i = 0; i < 8; i++) rdc(12'(276 + i * 32), 0);
    rdc(12'h00C, 0);
    wr(12'h110, 0);
    wr(12'h100, 880);
    wr(12'h104, 600);
    wr(12'h108, 12);
    u_fld.put(0, 0);
    wt(3);
    u_fld.put(0, 90000);
    lat(1, 4);
    wr(12'h10C, 20);
    u_fld.put(0, 0);
    wt(2);
    u_fld.put(0, 90000);
    wt(8);
    @(negedge clk);
    chk(st_o[0], 1);
    u_fld.put(0, 0);
    lat(0, 5);
    u_fld.put(0, 90000);
    lat(1, 4);
    wr(12'h10C, 0);
    bo(1, 0, 12'h110, 2);
    rdc(12'h110, 2);
    u_fld.put(0, 50000);
    wt(10);
    @(negedge clk);
    chk(st_o[0], 1);
    u_fld.put(0, 5000);
    lat(0, 7);
    results();
  end
endmodule
